/* File: design/mrburst_ctrl.sv */
// Mode registers MR0/MR1 decode and burst ordering of a DDR3 x8 device
//
// Overview of operation
// - Burst type bit selects sequential or interleaved
// - Length field: fixed chop, fixed eight, on-the-fly
// - Sequential read wraps inside groups of four
// - Interleaved read column is start XOR beat
// - Chop-four read tri-states last four slots
// - Chop-four write uses CA2 only, ascending
// - Eight-beat write ignores low column bits
// - Fixed chop write pulls write recovery in by two clocks
// - On-the-fly chop write keeps eight-beat timing
// - DLL reset bit clears itself when done
// - Write recovery field feeds auto-precharge timing
// - Precharge power-down DLL frozen or kept
// - MRS with bank one loads MR1
// - Self-refresh turns DLL off then on
// - Driver impedance from MR1 bits A1, A5
// - Commands delayed internally by additive latency
// - Output disable bit releases dq_oe; beat.drive still marks read beats
// - TDQS enable turns mask pin into strobe
// - MRS with bank zero loads MR0
`timescale 1ns/1ns
`include "mrburst_defs.svh"
module mrburst_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire mrburst_pkg::cmd_t cmd,
    input wire logic cke,
    input wire logic [5:0] cas_lat,
    input wire logic [5:0] cas_wr_lat,
    input wire logic dll_locked,
    output logic [15:0] mr0,
    output logic [15:0] mr1,
    output logic dll_reset,
    output logic dll_on,
    output logic [2:0] wr_recovery,
    output logic ppd_fast_exit,
    output logic [1:0] drive_imp,
    output logic [2:0] rtt_nom,
    output logic write_level,
    output logic tdqs_on,
    output logic dm_on,
    output logic [5:0] read_lat,
    output logic [5:0] write_lat,
    output mrburst_pkg::beat_t beat,
    output logic wr_internal,
    output logic wr_early,
    output logic rd_internal,
    output logic dq_oe
);
    // Pin inputs arrive from outside; two stages before any use
    // Limitation: the command word is not gray coded, so it must hold a full clock
    mrburst_pkg::cmd_t cmd_s1_r, cmd_r;
    logic cke_s1_r, cke_r, lock_s1_r, lock_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_s1_r <= '1;
            cmd_r <= '1;
            cke_s1_r <= 1'b0;
            cke_r <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_r <= 1'b0;
        end else begin
            cmd_s1_r <= cmd;
            cmd_r <= cmd_s1_r;
            cke_s1_r <= cke;
            cke_r <= cke_s1_r;
            lock_s1_r <= dll_locked;
            lock_r <= lock_s1_r;
        end
    end

    // Command decode on the synchronised pins
    logic is_mrs, is_rd, is_wr, is_srent, mrs0, mrs1;
    assign is_mrs = ~cmd_r.cs_b & ~cmd_r.ras_b & ~cmd_r.cas_b & ~cmd_r.we_b;
    assign is_rd = ~cmd_r.cs_b & cmd_r.ras_b & ~cmd_r.cas_b & cmd_r.we_b;
    assign is_wr = ~cmd_r.cs_b & cmd_r.ras_b & ~cmd_r.cas_b & ~cmd_r.we_b;
    // Refresh command with CKE low enters self-refresh
    assign is_srent = ~cmd_r.cs_b & ~cmd_r.ras_b & ~cmd_r.cas_b & cmd_r.we_b & ~cke_r;
    assign mrs0 = is_mrs & (cmd_r.ba == 3'h0);
    assign mrs1 = is_mrs & (cmd_r.ba == 3'h1);

    // MR0 load; DLL reset bit self-clears when the lock completes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mr0 <= `MR_RESET;
        end else if (mrs0) begin
            mr0 <= cmd_r.addr;
        end else if (mr0[`DLLRST_BIT] && lock_r) begin
            mr0[`DLLRST_BIT] <= 1'b0;
        end
    end

    // MR1 load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mr1 <= `MR_RESET;
        end else if (mrs1) begin
            mr1 <= cmd_r.addr;
        end
    end

    // Self-refresh tracking; DLL auto off inside, on again at exit
    logic in_sr_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_sr_r <= 1'b0;
        end else if (is_srent) begin
            in_sr_r <= 1'b1;
        end else if (cke_r) begin
            in_sr_r <= 1'b0;
        end
    end

    // Static decode of the mode fields
    assign dll_reset = mr0[`DLLRST_BIT];
    assign dll_on = ~mr1[`DLLDIS_BIT] & ~in_sr_r;
    assign wr_recovery = mr0[`WR_HI:`WR_LO];
    assign ppd_fast_exit = mr0[`PPD_BIT];
    assign drive_imp = {mr1[`DIC1_BIT], mr1[`DIC0_BIT]};
    assign rtt_nom = {mr1[`RTT2_BIT], mr1[`RTT1_BIT], mr1[`RTT0_BIT]};
    assign write_level = mr1[`WLVL_BIT];
    assign tdqs_on = mr1[`TDQS_BIT];
    assign dm_on = ~mr1[`TDQS_BIT];

    // Additive latency: 0, CL-1, CL-2
    logic [5:0] al;
    always_comb begin
        case (mr1[`AL_HI:`AL_LO])
            2'h1: al = cas_lat - 6'h01;
            2'h2: al = cas_lat - 6'h02;
            default: al = 6'h00;
        endcase
    end
    assign read_lat = al + cas_lat;
    assign write_lat = al + cas_wr_lat;

    // Commands wait AL clocks before internal issue
    logic [5:0] al_cnt_r;
    logic pend_rd_r, pend_wr_r, pend_bc4_r;
    logic [2:0] pend_col_r;
    logic bc4_cmd;
    always_comb begin
        case (mr0[`BL_HI:`BL_LO])
            `BL_FIX4: bc4_cmd = 1'b1;
            `BL_OTF: bc4_cmd = ~cmd_r.addr[`BC_BIT];
            default: bc4_cmd = 1'b0;
        endcase
    end
    logic issue;
    assign issue = (pend_rd_r | pend_wr_r) && (al_cnt_r == 6'h00);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            al_cnt_r <= 6'h00;
            pend_rd_r <= 1'b0;
            pend_wr_r <= 1'b0;
            pend_bc4_r <= 1'b0;
            pend_col_r <= 3'h0;
        end else if (is_rd || is_wr) begin
            al_cnt_r <= al;
            pend_rd_r <= is_rd;
            pend_wr_r <= is_wr;
            pend_bc4_r <= bc4_cmd;
            pend_col_r <= cmd_r.addr[2:0];
        end else if (issue) begin
            pend_rd_r <= 1'b0;
            pend_wr_r <= 1'b0;
        end else if (al_cnt_r != 6'h00) begin
            al_cnt_r <= al_cnt_r - 6'h01;
        end
    end
    assign rd_internal = issue & pend_rd_r;
    assign wr_internal = issue & pend_wr_r;
    // Only a fixed chop pulls write recovery in by two clocks
    assign wr_early = wr_internal & (mr0[`BL_HI:`BL_LO] == `BL_FIX4);

    // Beat sequencer: one beat slot per clock
    mrburst_pkg::burst_state_t state_r;
    logic [2:0] beat_r, start_r;
    logic bc4_r, ilv_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= mrburst_pkg::BURST_IDLE;
            beat_r <= 3'h0;
            start_r <= 3'h0;
            bc4_r <= 1'b0;
            ilv_r <= 1'b0;
        end else begin
            case (state_r)
                mrburst_pkg::BURST_IDLE: begin
                    if (issue) begin
                        state_r <= pend_rd_r ? mrburst_pkg::BURST_READ
                                             : mrburst_pkg::BURST_WRITE;
                        beat_r <= 3'h0;
                        // Writes drop low column bits: CA2 for chop, none for eight
                        if (pend_wr_r) begin
                            start_r <= pend_bc4_r ? {pend_col_r[2], 2'h0} : 3'h0;
                        end else begin
                            start_r <= pend_col_r;
                        end
                        bc4_r <= pend_bc4_r;
                        ilv_r <= mr0[`BT_BIT];
                    end
                end
                default: begin
                    beat_r <= beat_r + 3'h1;
                    if (beat_r == 3'h7) begin
                        state_r <= mrburst_pkg::BURST_IDLE;
                    end
                end
            endcase
        end
    end

    // Column for the current beat
    logic [2:0] col_c;
    always_comb begin
        if (state_r == mrburst_pkg::BURST_WRITE) begin
            col_c = start_r + beat_r;
        end else if (ilv_r) begin
            col_c = start_r ^ beat_r;
        end else begin
            // Wrap inside group of four, then switch group
            col_c = {start_r[2] ^ beat_r[2], start_r[1:0] + beat_r[1:0]};
        end
    end

    // Registered beat outputs
    logic live_c;
    assign live_c = (state_r != mrburst_pkg::BURST_IDLE) && !(bc4_r && beat_r[2]);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            beat <= '0;
            dq_oe <= 1'b0;
        end else begin
            beat.col <= col_c;
            beat.valid <= live_c;
            beat.drive <= live_c && (state_r == mrburst_pkg::BURST_READ);
            // Output disable overrides dq_oe read drive; beat.drive is not gated
            dq_oe <= live_c && (state_r == mrburst_pkg::BURST_READ)
                     && !mr1[`QOFF_BIT];
        end
    end

    // Checks on the mode registers and the self-clearing reset bit
    chk_mr0_load: assert property (@(posedge clk) disable iff (!rst_b)
        mrs0 |=> mr0 == $past(cmd_r.addr)) else $error("mr0 not loaded");
    chk_mr1_load: assert property (@(posedge clk) disable iff (!rst_b)
        mrs1 |=> mr1 == $past(cmd_r.addr)) else $error("mr1 not loaded");
    // An MRS to any other bank code must leave both registers untouched
    chk_mr0_keep: assert property (@(posedge clk) disable iff (!rst_b)
        (!mrs0 && !(mr0[`DLLRST_BIT] && lock_r)) |=> $stable(mr0))
        else $error("mr0 changed without a load");
    chk_mr1_keep: assert property (@(posedge clk) disable iff (!rst_b)
        !mrs1 |=> $stable(mr1)) else $error("mr1 changed without a load");
    chk_dll_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (dll_reset && lock_r && !mrs0) |=> !dll_reset) else $error("dll reset stuck");
    chk_dll_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (dll_reset && !lock_r && !mrs0) |=> dll_reset)
        else $error("dll reset cleared before lock");

    // Self-refresh parks the loop; exit restores what MR1 asks for
    chk_sr_dll_off: assert property (@(posedge clk) disable iff (!rst_b)
        is_srent |=> !dll_on) else $error("dll left on in self-refresh");
    chk_sr_dll_back: assert property (@(posedge clk) disable iff (!rst_b)
        (in_sr_r && cke_r && !is_srent && !mrs1) |=> dll_on == !mr1[`DLLDIS_BIT])
        else $error("dll not restored at self-refresh exit");

    // Burst length chosen per command
    chk_len_fix4: assert property (@(posedge clk) disable iff (!rst_b)
        ((is_rd || is_wr) && mr0[`BL_HI:`BL_LO] == `BL_FIX4) |=> pend_bc4_r)
        else $error("fixed chop not applied");
    chk_len_fix8: assert property (@(posedge clk) disable iff (!rst_b)
        ((is_rd || is_wr) && mr0[`BL_HI:`BL_LO] == `BL_FIX8) |=> !pend_bc4_r)
        else $error("fixed eight chopped");
    chk_len_otf: assert property (@(posedge clk) disable iff (!rst_b)
        ((is_rd || is_wr) && mr0[`BL_HI:`BL_LO] == `BL_OTF)
        |=> pend_bc4_r == !$past(cmd_r.addr[`BC_BIT]))
        else $error("on-the-fly length wrong");
    chk_burst_len: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_IDLE && issue)
        |=> (state_r != mrburst_pkg::BURST_IDLE) [*8]) else $error("burst too short");

    // Additive latency before internal issue
    chk_al_zero_rd: assert property (@(posedge clk) disable iff (!rst_b)
        (is_rd && al == 6'h00) |=> rd_internal) else $error("read issued late");
    chk_al_zero_wr: assert property (@(posedge clk) disable iff (!rst_b)
        (is_wr && al == 6'h00) |=> wr_internal) else $error("write issued late");
    // Four clocks of additive latency: command, four quiet cycles, then issue
    chk_al_delay: assert property (@(posedge clk) disable iff (!rst_b)
        (is_rd && al == 6'h04) ##1 !(is_rd || is_wr) [*4] |=> rd_internal)
        else $error("additive latency wrong");

    // Write timing reference depends on how the chop was chosen
    chk_early_fix: assert property (@(posedge clk) disable iff (!rst_b)
        wr_early |-> mr0[`BL_HI:`BL_LO] == `BL_FIX4) else $error("early write wrong");
    chk_early_set: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_internal && mr0[`BL_HI:`BL_LO] == `BL_FIX4) |-> wr_early)
        else $error("fixed chop write not early");
    chk_otf_late: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_internal && mr0[`BL_HI:`BL_LO] == `BL_OTF) |-> !wr_early)
        else $error("on-the-fly write pulled in");

    // Start column latched at issue
    chk_rd_start: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_IDLE && issue && pend_rd_r)
        |=> start_r == $past(pend_col_r)) else $error("read start column lost");
    chk_wr4_start: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_IDLE && issue && pend_wr_r && pend_bc4_r)
        |=> start_r == {$past(pend_col_r[2]), 2'h0})
        else $error("chop write start wrong");
    chk_wr8_start: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_IDLE && issue && pend_wr_r && !pend_bc4_r)
        |=> start_r == 3'h0) else $error("eight-beat write start not zero");
    chk_wr_start: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_WRITE) |-> start_r[1:0] == 2'h0)
        else $error("write start not aligned");

    // Beat order inside the burst
    chk_ilv_order: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_READ && ilv_r) |-> col_c == (start_r ^ beat_r))
        else $error("interleave order wrong");
    chk_seq_group: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_READ && !ilv_r && beat_r == 3'h4)
        |-> col_c[2] != start_r[2]) else $error("sequential group wrong");

    // Output drivers: chop tail, writes and output disable stay quiet
    chk_chop_tristate: assert property (@(posedge clk) disable iff (!rst_b)
        (bc4_r && beat_r[2]) |=> !dq_oe) else $error("chop drives late slots");
    chk_chop_valid: assert property (@(posedge clk) disable iff (!rst_b)
        (bc4_r && beat_r[2]) |=> !beat.valid) else $error("chop keeps late beats");
    chk_rd_drive: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_READ && !(bc4_r && beat_r[2]) && !mr1[`QOFF_BIT])
        |=> dq_oe) else $error("read beat not driven");
    chk_wr_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == mrburst_pkg::BURST_WRITE) |=> !dq_oe && !beat.drive)
        else $error("write drives the data pins");
    chk_qoff_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        $past(mr1[`QOFF_BIT]) |-> !dq_oe) else $error("output disable ignored");

    // Main scenarios
    cov_read: cover property (@(posedge clk) rd_internal);
    cov_write: cover property (@(posedge clk) wr_internal);
    cov_chop: cover property (@(posedge clk) bc4_r && beat_r == 3'h4);
    cov_otf_chop: cover property (@(posedge clk)
        (is_rd || is_wr) && mr0[`BL_HI:`BL_LO] == `BL_OTF && !cmd_r.addr[`BC_BIT]);
    cov_sr: cover property (@(posedge clk) in_sr_r);
endmodule

/* File: design/mrburst_defs.svh */
// Constants for the mode register and burst control block
`ifndef MRBURST_DEFS_SVH
`define MRBURST_DEFS_SVH
`define BL_LO 0
`define BL_HI 1
`define BT_BIT 3
`define CL_BIT 2
`define DLLRST_BIT 8
`define WR_LO 9
`define WR_HI 11
`define PPD_BIT 12
`define DLLDIS_BIT 0
`define DIC0_BIT 1
`define DIC1_BIT 5
`define RTT0_BIT 2
`define RTT1_BIT 6
`define RTT2_BIT 9
`define AL_LO 3
`define AL_HI 4
`define WLVL_BIT 7
`define TDQS_BIT 11
`define QOFF_BIT 12
`define BC_BIT 12
`define BL_FIX8 2'h0
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define MR_RESET 16'h0000
`define WR_EARLY 4'h2
`define LAT_MAX 6'h3f
`endif

/* File: design/mrburst_pkg.sv */
// Types shared by the mode register and burst control block
package mrburst_pkg;
    typedef struct packed {
        logic cs_b;
        logic ras_b;
        logic cas_b;
        logic we_b;
        logic [2:0] ba;
        logic [15:0] addr;
    } cmd_t;
    typedef struct packed {
        logic [2:0] col;
        logic valid;
        logic drive;
    } beat_t;
    typedef enum logic [1:0] {
        BURST_IDLE,
        BURST_READ,
        BURST_WRITE
    } burst_state_t;
endpackage

/* File: test/mrburst_host.sv */
// Controller-side model: drives command pins, clock enable and MRS writes
`timescale 1ns/1ns
module mrburst_host #(
    parameter int DLLK_CYC = 20,
    parameter logic [2:0] WR_MIN = 3'h1,
    parameter logic [7:0] RTT_OK = 8'h0f
) (
    input wire logic clk,
    output mrburst_pkg::cmd_t cmd,
    output logic cke
);
    int lock_left = 0;
    initial begin
        cmd = '1;
        cke = 1'b1;
    end
    // One command cycle; deselect flips the other pins so stale values never match
    task automatic send(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a,
                        input logic k);
        @(posedge clk);
        #1 cmd = {c, ba, a};
        cke = k;
        @(posedge clk);
        #1 cmd = {1'b1, ~cmd[21:0]};
    endtask
    // Mode writes, corrected for the settings a careful controller would refuse to program
    task automatic mrs(input logic [2:0] ba, input logic [15:0] a);
        logic [15:0] v;
        v = a;
        if (ba == 3'h1 && (v[0] || !(RTT_OK[{v[9], v[6], v[2]}] || v[7] && v[12]))) begin
            {v[9], v[6], v[2]} = 3'h0;
        end
        if (ba == 3'h0 && v[11:9] < WR_MIN) v[11:9] = WR_MIN;
        if (ba == 3'h0 && v[8]) lock_left = DLLK_CYC;
        send(4'h0, ba, v, 1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // Reads wait out the lock time; clock enable stays high meanwhile
    task automatic rw(input logic wr, input logic [15:0] a);
        while (lock_left > 0 && !wr) begin
            @(posedge clk);
            lock_left--;
        end
        send({3'h2, ~wr}, 3'h0, a, 1'b1);
    endtask
    task automatic sleep(input logic on);
        if (on) send(4'h1, 3'h0, 16'h0000, 1'b0);
        else begin
            @(posedge clk);
            #1 cke = 1'b1;
        end
    endtask
endmodule

/* File: test/mrburst_ctrl_tb_top.sv */
// Self-checking bench for the mode register and burst control block
`timescale 1ns/1ns
module mrburst_ctrl_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic dll_locked = 1'b0;
    logic [5:0] cas_lat = 6'h05;
    logic [5:0] cas_wr_lat = 6'h05;
    logic cke, dll_reset, dll_on, ppd_fast_exit, write_level, tdqs_on, dm_on;
    logic wr_internal, wr_early, rd_internal, dq_oe;
    logic [15:0] mr0, mr1;
    logic [2:0] wr_recovery, rtt_nom;
    logic [1:0] drive_imp;
    logic [5:0] read_lat, write_lat;
    mrburst_pkg::cmd_t cmd;
    mrburst_pkg::beat_t beat;
    int mismatches = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    mrburst_host host (.clk(clk), .cmd(cmd), .cke(cke));
    mrburst_ctrl DUT (.clk(clk), .rst_b(rst_b), .cmd(cmd), .cke(cke), .cas_lat(cas_lat),
        .cas_wr_lat(cas_wr_lat), .dll_locked(dll_locked), .mr0(mr0), .mr1(mr1),
        .dll_reset(dll_reset), .dll_on(dll_on), .wr_recovery(wr_recovery),
        .ppd_fast_exit(ppd_fast_exit), .drive_imp(drive_imp), .rtt_nom(rtt_nom),
        .write_level(write_level), .tdqs_on(tdqs_on), .dm_on(dm_on), .read_lat(read_lat),
        .write_lat(write_lat), .beat(beat), .wr_internal(wr_internal), .wr_early(wr_early),
        .rd_internal(rd_internal), .dq_oe(dq_oe));
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // Bounded wait: 0 beat valid, 1 internal write, 2 internal read
    task automatic wait_on(input int sel, output int n);
        logic hit;
        for (n = 0; n < 64; n++) begin
            @(negedge clk);
            hit = sel == 0 ? beat.valid : sel == 1 ? wr_internal : rd_internal;
            if (hit === 1'b1) return;
        end
        mismatches++;
        $display("[ERR] %0t wait expired", $time);
        give_verdict();
    endtask
    function automatic logic [2:0] exp_col(input logic [2:0] s, input logic [2:0] b,
                                           input logic il);
        return il ? s ^ b : {s[2] ^ b[2], s[1:0] + b[1:0]};
    endfunction
    // Mode m: 0 fixed eight, 1 on-the-fly chop, 2 fixed chop, 3 on-the-fly eight
    task automatic burst(input logic wr, input logic il, input int m, input logic [2:0] c);
        int n;
        logic chop;
        logic [2:0] s;
        chop = m == 1 || m == 2;
        s = !wr ? c : chop ? {c[2], 2'b00} : 3'h0;
        host.rw(wr, {3'h0, m != 1, 9'h000, c});
        if (wr) begin
            wait_on(1, n);
            check(wr_early, m == 2);
        end
        wait_on(0, n);
        for (int b = 0; b < 8; b++) begin
            if (b > 0) @(negedge clk);
            if (b < 4 || !chop) begin
                check(beat.col, wr ? s + 3'(b) : exp_col(s, 3'(b), il));
                check({beat.valid, beat.drive, dq_oe}, {1'b1, !wr, !wr});
            end else check({beat.valid, beat.drive, dq_oe}, 3'h0);
        end
    endtask
    task automatic t_fields();
        check({dm_on, dll_on, tdqs_on, dll_reset, dq_oe, mr0}, 21'h180000);
        host.mrs(3'h0, 16'h1a0a);
        check(mr0, 16'h1a0a);
        check({wr_recovery, ppd_fast_exit}, 16'h000b);
        host.mrs(3'h1, 16'h08a4);
        check(mr1, 16'h08a4);
        check({drive_imp, rtt_nom, tdqs_on, dm_on, write_level}, 16'h008d);
        host.mrs(3'h2, 16'hffff);
        check(mr0 ^ mr1, 16'h12ae);
        host.mrs(3'h1, 16'h0000);
        check({tdqs_on, dm_on}, 16'h0001);
        $display("test done: fields");
    endtask
    // Every length code and both burst types, all read starts, two write starts
    task automatic t_order();
        for (int il = 0; il < 2; il++) begin
            for (int m = 0; m < 4; m++) begin
                host.mrs(3'h0, {12'h000, 1'(il), 1'b0, 2'(m == 3 ? 1 : m)});
                for (int c = 0; c < 8; c++) burst(1'b0, 1'(il), m, 3'(c));
                burst(1'b1, 1'(il), m, 3'h5);
                burst(1'b1, 1'(il), m, 3'h3);
            end
        end
        $display("test done: order");
    endtask
    task automatic t_latency();
        int n0, n1;
        host.rw(1'b0, 16'h1000);
        wait_on(2, n0);
        repeat (12) @(negedge clk);
        host.mrs(3'h1, 16'h0008);
        check({read_lat, write_lat}, 16'h0249);
        host.rw(1'b0, 16'h1000);
        wait_on(2, n1);
        repeat (12) @(negedge clk);
        check(16'(n1 - n0), 16'h0004);
        @(posedge clk);
        #1 cas_lat = 6'h07;
        host.mrs(3'h1, 16'h0010);
        check({read_lat, write_lat}, 16'h030a);
        host.mrs(3'h1, 16'h0000);
        $display("test done: latency");
    endtask
    // Lock handshake, self-refresh, disabled loop and released outputs
    task automatic t_dll();
        logic oe, vld;
        host.mrs(3'h0, 16'h0100);
        repeat (5) @(negedge clk);
        check(dll_reset, 1'b1);
        @(posedge clk);
        #1 dll_locked = 1'b1;
        repeat (6) @(negedge clk);
        check({dll_reset, mr0[8]}, 16'h0000);
        burst(1'b0, 1'b0, 0, 3'h2);
        host.sleep(1'b1);
        repeat (4) @(negedge clk);
        check(dll_on, 1'b0);
        host.sleep(1'b0);
        repeat (4) @(negedge clk);
        check(dll_on, 1'b1);
        host.mrs(3'h1, 16'h0205);
        check({dll_on, rtt_nom, mr1}, {1'b0, 3'h0, 16'h0001});
        host.mrs(3'h1, 16'h1000);
        host.rw(1'b0, 16'h1000);
        oe = 1'b0;
        vld = 1'b0;
        repeat (16) begin
            @(negedge clk);
            oe = oe | dq_oe;
            vld = vld | beat.valid;
        end
        check({vld, oe}, 2'b10);
        $display("test done: dll");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        @(negedge clk);
        t_fields();
        t_order();
        t_latency();
        t_dll();
        give_verdict();
    end
endmodule
